// File: hdl/sfes_pkg.sv
// Opcodes, field positions, carrier types and decode helpers
package sfes_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_CLEAR_STATUS  = 8'h30;
  localparam logic [7:0] OP_BLOCK_ERASE   = 8'hD8;
  localparam logic [7:0] OP_BLOCK_ERASE_W = 8'hDC;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7A;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_READ_W        = 8'h13;
  localparam logic [7:0] OP_RD_STATUS_ONE = 8'h05;
  localparam logic [7:0] OP_RD_STATUS_TWO = 8'h07;
  localparam logic [7:0] OP_RD_ANY_REG    = 8'h65;
  localparam logic [7:0] OP_RD_CFG_ONE    = 8'h35;
  localparam logic [7:0] OP_RD_CFG_TWO    = 8'h15;
  localparam logic [7:0] OP_RD_CFG_THREE  = 8'h33;
  localparam logic [7:0] OP_PROG          = 8'h02;
  localparam logic [7:0] OP_PROG_W        = 8'h12;
  localparam logic [7:0] OP_QPROG         = 8'h32;
  localparam logic [7:0] OP_QPROG_W       = 8'h34;

  // ****************************************
  // Field sizes
  // ****************************************
  localparam int         CNT_W       = 12;
  localparam logic [5:0] ADDR_NARROW = 6'h18;
  localparam logic [5:0] ADDR_WIDE   = 6'h20;
  localparam logic [11:0] OPC_BITS   = 12'h008;
  localparam logic [11:0] DATA_BITS  = 12'h008;
  localparam logic [11:0] STEP_ONE   = 12'h001;
  localparam logic [11:0] STEP_QUAD  = 12'h004;
  localparam int         BLOCK_LSB   = 16;
  localparam int         PAGE_LSB    = 8;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [7:0]       opcode;
    logic [31:0]      addr;
    logic [CNT_W-1:0] nbits;
  } sfes_frame_t;

  typedef struct packed {
    logic write_in_progress;
    logic write_enable_latch;
    logic e_err;
    logic e_susp;
    logic p_susp;
  } sfes_status_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [31:0] addr;
  } sfes_fwd_t;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [5:0] sfes_addr_bits(input logic [7:0] op, input logic wide_cfg);
    logic [5:0] bits;
    bits = wide_cfg ? ADDR_WIDE : ADDR_NARROW;
    if (op == OP_BLOCK_ERASE_W || op == OP_PROG_W || op == OP_QPROG_W || op == OP_READ_W) begin
      bits = ADDR_WIDE;
    end
    return bits;
  endfunction : sfes_addr_bits

  function automatic logic sfes_susp_allowed(input logic [7:0] op, input logic erase_susp);
    logic ok;
    ok = (op == OP_READ) || (op == OP_READ_W) || (op == OP_RD_STATUS_ONE) ||
         (op == OP_RD_STATUS_TWO) || (op == OP_RD_ANY_REG) || (op == OP_RD_CFG_ONE) ||
         (op == OP_RD_CFG_TWO) || (op == OP_RD_CFG_THREE) || (op == OP_RESUME) ||
         (op == OP_WRITE_ENABLE) || (op == OP_WRITE_DISABLE) || (op == OP_CLEAR_STATUS);
    if (erase_susp && (op == OP_PROG || op == OP_PROG_W || op == OP_QPROG || op == OP_QPROG_W)) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : sfes_susp_allowed

endpackage : sfes_pkg

// File: hdl/sfes_link_rx.sv
// Serial link receiver: shifts opcode and address in on the link clock
`timescale 1ns/1ps
module sfes_link_rx import sfes_pkg::*; (
  // Link pins
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic [3:0]  i_io,
  // Configuration from the reference domain
  input  wire logic        i_quad_mode,
  input  wire logic        i_addr_wide,
  // Captured frame
  output      sfes_frame_t o_frame
);

  // ****************************************
  // Frame marker, cleared while select is high
  // ****************************************
  logic in_frame_ff;

  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      in_frame_ff <= 1'b0;
    end else begin
      in_frame_ff <= 1'b1;
    end
  end

  // ****************************************
  // Shifter
  // ****************************************
  logic             quad_s1_ff, quad_s2_ff, wide_s1_ff, wide_s2_ff;
  logic [31:0]      shift_ff, nxt_shift;
  logic [7:0]       op_ff, nxt_op;
  logic [31:0]      addr_ff, nxt_addr;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] cnt_base, step;
  logic [5:0]       alen;

  always_comb begin
    cnt_base = in_frame_ff ? cnt_ff : '0;
    if (quad_s2_ff) begin
      nxt_shift = {shift_ff[27:0], i_io};
      step      = STEP_QUAD;
    end else begin
      nxt_shift = {shift_ff[30:0], i_io[0]};
      step      = STEP_ONE;
    end
    nxt_cnt = (&cnt_base) ? cnt_base : cnt_base + step;
    nxt_op  = (nxt_cnt == OPC_BITS) ? nxt_shift[7:0] : op_ff;
    alen    = sfes_addr_bits(op_ff, wide_s2_ff);
    nxt_addr = addr_ff;
    if (nxt_cnt == OPC_BITS + {6'h00, alen}) begin
      nxt_addr = (alen == ADDR_WIDE) ? nxt_shift : {8'h00, nxt_shift[23:0]};
    end
  end

  always_ff @(posedge i_sclk) begin
    quad_s1_ff <= i_quad_mode;
    quad_s2_ff <= quad_s1_ff;
    wide_s1_ff <= i_addr_wide;
    wide_s2_ff <= wide_s1_ff;
    shift_ff   <= nxt_shift;
    op_ff      <= nxt_op;
    addr_ff    <= nxt_addr;
    cnt_ff     <= nxt_cnt;
  end

  assign o_frame = '{opcode: op_ff, addr: addr_ff, nbits: cnt_ff};

endmodule : sfes_link_rx

// File: hdl/sfes_top.sv
// Erase, chip erase and suspend/resume sequencer of a serial flash
// Overview of operation
// - Block erase needs write enable latch set
// - D8 address width per config, DC wide
// - Select rise off last address bit discards
// - Erase runs with write in progress high
// - Protected block: no erase, set error
// - Any protected part of block blocks erase
// - Quad mode shifts command on four lines
// - Chip erase 60/C7, latch, rise after eight
// - Any protection refuses chip erase with error
// - Quad mode carries chip erase byte
// - Suspend program or block erase, never chip
// - Suspend clears busy, sets suspend flag
// - Reads outside suspended block or page allowed
// - Erase suspend allows program; program suspend reads
// - Resume does not recheck protection
// - Suspend while suspended is ignored
// - Reads of array and status permitted
// - Configuration reads permitted in suspend
// - Resume opcode restarts suspended operation
// - Program in erase suspend needs no program suspended
`timescale 1ns/1ps
module sfes_top import sfes_pkg::*; #(
  parameter int unsigned NUM_BLOCKS   = 512,
  parameter int unsigned ERASE_CYCLES = 20000,
  parameter int unsigned CHIP_CYCLES  = 100000,
  parameter int unsigned PROG_CYCLES  = 5000,
  parameter int unsigned SUSP_CYCLES  = 100
) (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_sys_rst,
  // Link
  input  wire logic                  i_sclk,
  input  wire logic                  i_cs_n,
  input  wire logic [3:0]            i_io,
  // Configuration
  input  wire logic                  i_quad_mode,
  input  wire logic                  i_addr_wide,
  // Protection, one bit per 64 KB block
  input  wire logic [NUM_BLOCKS-1:0] i_prot_map,
  // Status and forwarded commands
  output      sfes_status_t          o_status,
  output      sfes_fwd_t             o_fwd
);

  localparam int BLK_W = $clog2(NUM_BLOCKS);

  // ****************************************
  // Parameter check
  // ****************************************
  if (NUM_BLOCKS < 2 || BLK_W > 16 || ERASE_CYCLES < 1 || CHIP_CYCLES < 1 ||
      PROG_CYCLES < 1 || SUSP_CYCLES < 1) begin : g_bad_param
    $error("sfes_top: unsupported parameter values");
  end

  // ****************************************
  // Link receiver
  // ****************************************
  sfes_frame_t frame;

  sfes_link_rx u_link_rx (
    .i_sclk      (i_sclk),
    .i_cs_n      (i_cs_n),
    .i_io        (i_io),
    .i_quad_mode (i_quad_mode),
    .i_addr_wide (i_addr_wide),
    .o_frame     (frame)
  );

  // ****************************************
  // Select synchroniser and frame end
  // ****************************************
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
  logic cs_rise;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
    end else begin
      cs_s1_ff <= i_cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
    end
  end

  assign cs_rise = cs_s2_ff & ~cs_s3_ff;

  // ****************************************
  // Frame decode
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_CHIP, ST_PROG, ST_SUSP} sfes_state_t;

  sfes_state_t      state_ff, nxt_state;
  logic [7:0]       op;
  logic [5:0]       alen;
  logic [CNT_W-1:0] addr_end;
  logic [BLK_W-1:0] blk;
  logic             len_op, len_addr, len_prog;
  logic             is_be, is_ce, is_prog, is_read, is_stat;
  logic             suspended, busy, allowed;
  logic             be_go, ce_go;
  logic             esusp_ff, psusp_ff, wel_ff;

  assign op        = frame.opcode;
  assign alen      = sfes_addr_bits(op, i_addr_wide);
  assign addr_end  = OPC_BITS + {6'h00, alen};
  assign blk       = frame.addr[BLOCK_LSB +: BLK_W];
  assign len_op    = frame.nbits == OPC_BITS;
  assign len_addr  = frame.nbits == addr_end;
  assign len_prog  = (frame.nbits >= addr_end + DATA_BITS) && (frame.nbits[2:0] == 3'h0);
  assign is_be     = (op == OP_BLOCK_ERASE) || (op == OP_BLOCK_ERASE_W);
  assign is_ce     = (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B);
  assign is_prog   = (op == OP_PROG) || (op == OP_PROG_W) || (op == OP_QPROG) ||
                     (op == OP_QPROG_W);
  assign is_read   = (op == OP_READ) || (op == OP_READ_W);
  assign is_stat   = (op == OP_RD_STATUS_ONE) || (op == OP_RD_STATUS_TWO) ||
                     (op == OP_RD_ANY_REG);
  assign suspended = esusp_ff | psusp_ff;
  assign busy      = state_ff != ST_IDLE;
  assign allowed   = sfes_susp_allowed(op, esusp_ff);
  assign be_go     = cs_rise & ~busy & ~suspended & is_be & len_addr & wel_ff;
  assign ce_go     = cs_rise & ~busy & ~suspended & is_ce & len_op & wel_ff;

  // ****************************************
  // Sequencer
  // ****************************************
  logic [31:0]         cnt_ff, nxt_cnt;
  logic [31:0]         erase_rem_ff, nxt_erase_rem;
  logic [31:0]         prog_rem_ff, nxt_prog_rem;
  logic [BLK_W-1:0]    erase_blk_ff, nxt_erase_blk;
  logic [31-PAGE_LSB:0] prog_page_ff, nxt_prog_page;
  logic                susp_prog_ff, nxt_susp_prog;
  logic                nxt_wel, eerr_ff, nxt_eerr, nxt_esusp, nxt_psusp;
  logic                wip_ff, nxt_wip;
  sfes_fwd_t           fwd_ff, nxt_fwd;
  logic                rd_blocked;

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_erase_rem = erase_rem_ff;
    nxt_prog_rem  = prog_rem_ff;
    nxt_erase_blk = erase_blk_ff;
    nxt_prog_page = prog_page_ff;
    nxt_susp_prog = susp_prog_ff;
    nxt_wel       = wel_ff;
    nxt_eerr      = eerr_ff;
    nxt_esusp     = esusp_ff;
    nxt_psusp     = psusp_ff;
    nxt_fwd       = '0;
    rd_blocked    = (esusp_ff && blk == erase_blk_ff) ||
                    (psusp_ff && frame.addr[31:PAGE_LSB] == prog_page_ff);
    unique case (state_ff)
      ST_IDLE: begin
      end
      ST_ERASE, ST_CHIP, ST_PROG: begin
        nxt_cnt = cnt_ff - 32'h1;
        if (cnt_ff == 32'h1) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SUSP: begin
        nxt_cnt = cnt_ff - 32'h1;
        if (cnt_ff == 32'h1) begin
          nxt_state = ST_IDLE;
          if (susp_prog_ff) begin
            nxt_psusp = 1'b1;
          end else begin
            nxt_esusp = 1'b1;
          end
        end
      end
    endcase
    if (cs_rise) begin
      if (busy) begin
        if (op == OP_SUSPEND && len_op && !suspended &&
            (state_ff == ST_ERASE || state_ff == ST_PROG)) begin
          nxt_susp_prog = state_ff == ST_PROG;
          if (state_ff == ST_PROG) begin
            nxt_prog_rem = cnt_ff;
          end else begin
            nxt_erase_rem = cnt_ff;
          end
          nxt_state = ST_SUSP;
          nxt_cnt   = 32'(SUSP_CYCLES);
        end else if (is_stat) begin
          nxt_fwd = '{valid: 1'b1, opcode: op, addr: frame.addr};
        end
      end else if (suspended && !allowed) begin
        nxt_fwd = '0;
      end else if (op == OP_WRITE_ENABLE && len_op) begin
        nxt_wel = 1'b1;
      end else if (op == OP_WRITE_DISABLE && len_op) begin
        nxt_wel = 1'b0;
      end else if (op == OP_CLEAR_STATUS && len_op) begin
        nxt_eerr = 1'b0;
      end else if (be_go) begin
        nxt_wel = 1'b0;
        if (i_prot_map[blk]) begin
          nxt_eerr = 1'b1;
        end else begin
          nxt_state     = ST_ERASE;
          nxt_cnt       = 32'(ERASE_CYCLES);
          nxt_erase_blk = blk;
        end
      end else if (ce_go) begin
        nxt_wel = 1'b0;
        if (|i_prot_map) begin
          nxt_eerr = 1'b1;
        end else begin
          nxt_state = ST_CHIP;
          nxt_cnt   = 32'(CHIP_CYCLES);
        end
      end else if (is_prog) begin
        if (len_prog && wel_ff && !psusp_ff) begin
          nxt_wel       = 1'b0;
          nxt_state     = ST_PROG;
          nxt_cnt       = 32'(PROG_CYCLES);
          nxt_prog_page = frame.addr[31:PAGE_LSB];
        end
      end else if (op == OP_RESUME && len_op) begin
        if (psusp_ff) begin
          nxt_psusp = 1'b0;
          nxt_state = ST_PROG;
          nxt_cnt   = prog_rem_ff;
        end else if (esusp_ff) begin
          nxt_esusp = 1'b0;
          nxt_state = ST_ERASE;
          nxt_cnt   = erase_rem_ff;
        end
      end else if (!(is_be || is_ce || op == OP_SUSPEND || (is_read && rd_blocked))) begin
        nxt_fwd = '{valid: 1'b1, opcode: op, addr: frame.addr};
      end
    end
    nxt_wip = nxt_state != ST_IDLE;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= '0;
      erase_rem_ff <= '0;
      prog_rem_ff  <= '0;
      erase_blk_ff <= '0;
      prog_page_ff <= '0;
      susp_prog_ff <= 1'b0;
      wel_ff       <= 1'b0;
      eerr_ff      <= 1'b0;
      esusp_ff     <= 1'b0;
      psusp_ff     <= 1'b0;
      wip_ff       <= 1'b0;
      fwd_ff       <= '0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      erase_rem_ff <= nxt_erase_rem;
      prog_rem_ff  <= nxt_prog_rem;
      erase_blk_ff <= nxt_erase_blk;
      prog_page_ff <= nxt_prog_page;
      susp_prog_ff <= nxt_susp_prog;
      wel_ff       <= nxt_wel;
      eerr_ff      <= nxt_eerr;
      esusp_ff     <= nxt_esusp;
      psusp_ff     <= nxt_psusp;
      wip_ff       <= nxt_wip;
      fwd_ff       <= nxt_fwd;
    end
  end

  assign o_status = '{write_in_progress: wip_ff, write_enable_latch: wel_ff, e_err: eerr_ff,
                      e_susp: esusp_ff, p_susp: psusp_ff};
  assign o_fwd    = fwd_ff;

  // ****************************************
  // Checks
  // ****************************************
  AST_BE_START: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    be_go && !i_prot_map[blk] |=> wip_ff && state_ff == ST_ERASE)
    else $error("block erase did not start");

  AST_BE_NO_LATCH: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cs_rise && !busy && !suspended && is_be && !wel_ff |=> !wip_ff)
    else $error("block erase started without write enable");

  AST_BE_BAD_LEN: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cs_rise && !busy && is_be && !len_addr |=> !wip_ff && $stable(eerr_ff))
    else $error("block erase with wrong length acted");

  AST_BE_PROT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    be_go && i_prot_map[blk] |=> eerr_ff && !wip_ff)
    else $error("protected block erase not refused");

  AST_CE_PROT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ce_go && (|i_prot_map) |=> eerr_ff && state_ff == ST_IDLE)
    else $error("chip erase with protection not refused");

  AST_CE_NO_SUSP: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state_ff == ST_CHIP && cnt_ff > 32'h2 |=> state_ff == ST_CHIP ##1 !suspended)
    else $error("chip erase was suspended");

  AST_SUSP_DONE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state_ff == ST_SUSP && cnt_ff == 32'h1 |=> !wip_ff && (esusp_ff || psusp_ff))
    else $error("suspend did not end with flag set");

  AST_NO_NEST: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cs_rise && suspended && op == OP_SUSPEND |=> state_ff != ST_SUSP)
    else $error("nested suspend accepted");

  AST_RD_BLOCKED: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cs_rise && !busy && is_read && rd_blocked |=> !fwd_ff.valid)
    else $error("read of suspended area forwarded");

  AST_IGNORE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cs_rise && !busy && suspended && !allowed |=> $stable(o_status) && !fwd_ff.valid)
    else $error("disallowed command in suspend changed state");

endmodule : sfes_top

// File: dv/sfes_host_model.sv
// Host link controller model driving select, clock and data lines
`timescale 1ns/1ps
module sfes_host_model import sfes_pkg::*; (
  // Mode
  input  wire logic       i_quad,
  // Link pins
  output      logic       o_sclk,
  output      logic       o_cs_n,
  output      logic [3:0] o_io
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io   = 4'hA;
  end
  // ****************************************
  // Frame, MSB first, clock idle low
  // ****************************************
  task automatic send(input logic [63:0] bits, input int n);
    int i;
    #7;
    o_cs_n = 1'b0;
    for (i = 0; i < n; i = i + (i_quad ? 4 : 1)) begin
      if (i_quad) o_io = bits[63-i -: 4];
      else o_io = {~o_io[3:1], bits[63-i]};
      #15 o_sclk = 1'b1;
      #15 o_sclk = 1'b0;
    end
    #5 o_cs_n = 1'b1;
    o_io = ~o_io;
    #60;
  endtask : send
endmodule : sfes_host_model

// File: dv/testbench.sv
// Self-checking bench for the erase and suspend sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] t=%0t got %0h expected %0h", $time, got, exp); end end
module testbench import sfes_pkg::*;;
  localparam int NB = 512;
  localparam int EC = 50;
  logic            i_ref_clk;
  logic            i_sys_rst;
  logic            i_quad_mode;
  logic            i_addr_wide;
  logic [NB-1:0]   i_prot_map;
  wire logic       sclk;
  wire logic       cs_n;
  wire logic [3:0] io;
  sfes_status_t    o_status;
  sfes_fwd_t       o_fwd;
  int              err_total;
  int              total_checks;
  int              cyc;
  int              fwd_cnt;
  int              n;
  int              aw;
  logic [7:0]      fwd_op;
  logic [31:0]     fwd_addr;
  logic [7:0]      rd_ops [6] = '{OP_RD_STATUS_ONE, OP_RD_STATUS_TWO, OP_RD_ANY_REG,
                                  OP_RD_CFG_ONE, OP_RD_CFG_TWO, OP_RD_CFG_THREE};

  sfes_host_model u_sfes_host_model (.i_quad(i_quad_mode), .o_sclk(sclk), .o_cs_n(cs_n),
                                     .o_io(io));
  sfes_top #(.NUM_BLOCKS(NB), .ERASE_CYCLES(EC), .CHIP_CYCLES(80), .PROG_CYCLES(60),
             .SUSP_CYCLES(5)) u_sfes_top (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io),
    .i_quad_mode(i_quad_mode), .i_addr_wide(i_addr_wide), .i_prot_map(i_prot_map),
    .o_status(o_status), .o_fwd(o_fwd));

  initial i_ref_clk = 1'b0;
  always #5 i_ref_clk = ~i_ref_clk;

  // ****************************************
  // Forward monitor and timeout
  // ****************************************
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (o_fwd.valid === 1'b1) begin
      fwd_cnt <= fwd_cnt + 1;
      fwd_op  <= o_fwd.opcode;
      fwd_addr <= o_fwd.addr;
    end
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int abits,
                       input int extra);
    logic [63:0] v;
    v = {op, 56'h0};
    if (abits > 0) v[55:24] = addr << (32 - abits);
    v[55-abits -: 8] = 8'hA5;
    u_sfes_host_model.send(v, 8 + abits + extra);
    repeat (6) @(posedge i_ref_clk);
  endtask : frame

  task automatic st(input logic [4:0] e);
    `CHK(o_status, e)
  endtask : st

  task automatic wait_idle(input int lim);
    n = 0;
    while (o_status.write_in_progress !== 1'b0 && n < lim) begin
      @(posedge i_ref_clk);
      n++;
    end
  endtask : wait_idle

  task automatic fwd_check(input logic [7:0] op, input logic [31:0] addr, input int abits,
                           input logic exp);
    int c0;
    c0 = fwd_cnt;
    frame(op, addr, abits, 0);
    `CHK(fwd_cnt - c0, exp ? 1 : 0)
    if (exp) `CHK(fwd_op, op)
    if (exp && abits > 0) `CHK(fwd_addr, addr)
  endtask : fwd_check

  task automatic end_test(input string s);
    $display("Test %s done, errors so far %0d", s, err_total);
  endtask : end_test

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    i_sys_rst    = 1'b1;
    i_quad_mode  = 1'b0;
    i_addr_wide  = 1'b0;
    i_prot_map   = '0;
    err_total    = 0;
    total_checks = 0;
    cyc          = 0;
    fwd_cnt      = 0;
    fwd_op       = 8'h00;
    fwd_addr     = 32'h0;
    aw           = 24;
    repeat (8) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    st(5'h00);
    frame(OP_BLOCK_ERASE, 32'h0001_0000, 24, 0);
    st(5'h00);
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    st(5'h08);
    frame(OP_BLOCK_ERASE, 32'h0001_0000, 24, -1);
    st(5'h08);
    frame(OP_BLOCK_ERASE, 32'h0001_0000, 24, 1);
    st(5'h08);
    frame(OP_BLOCK_ERASE, 32'h0001_0000, 24, 0);
    st(5'h10);
    wait_idle(200);
    `CHK(n >= EC - 15 && n <= EC - 5, 1'b1)
    st(5'h00);
    end_test("block_erase");
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_PROG, 32'h0001_0200, 24, 8);
    frame(OP_SUSPEND, 32'h0, 0, 0);
    wait_idle(20);
    st(5'h01);
    fwd_check(OP_READ, 32'h0001_0210, 24, 1'b0);
    fwd_check(OP_READ, 32'h0001_0300, 24, 1'b1);
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_PROG, 32'h0004_0000, 24, 8);
    st(5'h09);
    frame(OP_RESUME, 32'h0, 0, 0);
    st(5'h18);
    wait_idle(100);
    frame(OP_WRITE_DISABLE, 32'h0, 0, 0);
    st(5'h00);
    end_test("program_suspend");
    i_prot_map[3] <= 1'b1;
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_BLOCK_ERASE_W, 32'h0003_8000, 32, 0);
    st(5'h04);
    frame(OP_CLEAR_STATUS, 32'h0, 0, 0);
    i_addr_wide <= 1'b1;
    aw = 32;
    frame(8'hFF, 32'h0, 0, 0);
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_BLOCK_ERASE, 32'h0003_FFFF, 32, 0);
    st(5'h04);
    frame(OP_CLEAR_STATUS, 32'h0, 0, 0);
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_CHIP_ERASE_A, 32'h0, 0, 0);
    st(5'h04);
    frame(OP_CLEAR_STATUS, 32'h0, 0, 0);
    i_prot_map <= '0;
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_CHIP_ERASE_B, 32'h0, 0, 1);
    st(5'h08);
    frame(OP_CHIP_ERASE_B, 32'h0, 0, 0);
    st(5'h10);
    frame(OP_SUSPEND, 32'h0, 0, 0);
    repeat (8) @(posedge i_ref_clk);
    st(5'h10);
    wait_idle(300);
    st(5'h00);
    end_test("protect_and_chip");
    i_quad_mode <= 1'b1;
    frame(8'hFF, 32'h0, 0, 0);
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_BLOCK_ERASE, 32'h0002_0000, aw, 0);
    st(5'h10);
    frame(OP_SUSPEND, 32'h0, 0, 0);
    wait_idle(20);
    st(5'h02);
    frame(OP_SUSPEND, 32'h0, 0, 0);
    st(5'h02);
    i_prot_map[2] <= 1'b1;
    fwd_check(OP_READ, 32'h0005_0000, aw, 1'b1);
    fwd_check(OP_READ, 32'h0002_0100, aw, 1'b0);
    fwd_check(OP_READ_W, 32'h0002_0100, 32, 1'b0);
    foreach (rd_ops[k]) fwd_check(rd_ops[k], 32'h0, 0, 1'b1);
    fwd_check(8'h9F, 32'h0, 0, 1'b0);
    st(5'h02);
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_PROG, 32'h0007_0000, aw, 8);
    st(5'h12);
    wait_idle(100);
    frame(OP_RESUME, 32'h0, 0, 0);
    st(5'h10);
    wait_idle(200);
    st(5'h00);
    frame(OP_WRITE_ENABLE, 32'h0, 0, 0);
    frame(OP_CHIP_ERASE_A, 32'h0, 0, 0);
    st(5'h04);
    end_test("quad_erase_suspend");
    print_verdict();
  end
endmodule : testbench
